// >>> verilog/sblc_map.vh
// Constants of the serial boot loader checking block.
`ifndef SBLC_MAP_VH
`define SBLC_MAP_VH
`define SBLC_ERR_BAUD     8'h62
`define SBLC_ERR_CMD      8'h63
`define SBLC_ERR_FRAME    8'hA1
`define SBLC_ERR_OVERRUN  8'hA3
`define SBLC_MARK         8'h3A
`define SBLC_BYTE_FF      8'hFF
`define SBLC_REC_DATA     8'h00
`define SBLC_REC_END      8'h01
`define SBLC_REC_EXT      8'h02
`define SBLC_EXT_LEN      8'h02
`define SBLC_END_LEN      8'h00
`define SBLC_EXT_LIMIT    16'h1000
`define SBLC_FLASH_A_LO   20'h0_4000
`define SBLC_FLASH_A_HI   20'h0_7EFF
`define SBLC_FLASH_B_LO   20'hF_FF00
`define SBLC_FLASH_B_HI   20'hF_FFFF
`define SBLC_BLANK_LO     20'hF_FFE0
`define SBLC_PW_CEIL      20'h0_7F00
`define SBLC_PW_MIN       8'h08
`define SBLC_PW_ADDR_LEN  3'h6
`define SBLC_ID_FIRST     5'h09
`define SBLC_ID_LAST      5'h12
`define SBLC_ST_FIRST     5'h09
`define SBLC_ST_LAST      5'h0C
`define SBLC_ERR_REPEAT   2'h3
`define SBLC_MODE_WRITE   3'h0
`define SBLC_MODE_RAM     3'h1
`define SBLC_MODE_SUM     3'h2
`define SBLC_MODE_ID      3'h3
`define SBLC_MODE_STATUS  3'h4
`define SBLC_MODE_ERASE   3'h5
`define SBLC_MODE_PROTECT 3'h6
`define SBLC_HP_MARK      3'h0
`define SBLC_HP_LEN       3'h1
`define SBLC_HP_ADDR_H    3'h2
`define SBLC_HP_ADDR_L    3'h3
`define SBLC_HP_TYPE      3'h4
`define SBLC_HP_DATA      3'h5
`define SBLC_HP_CSUM      3'h6
`endif

// >>> verilog/sblc_checker.v
// Error replies, checksums, record parser and password check of the serial boot loader.
`timescale 1ns/1ps
`include "sblc_map.vh"
module sblc_checker (
    // Clock and reset.
    input  wire        core_clk,
    input  wire        rst_n,
    // Command phase events from the framing logic.
    input  wire        cmd_start,
    input  wire [2:0]  cmd_mode,
    input  wire        pw_needed,
    input  wire        err_baud,
    input  wire        err_cmd,
    input  wire        erase_chip,
    input  wire        erase_done,
    input  wire [19:0] erase_lo,
    input  wire [19:0] erase_hi,
    // Received byte stream.
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire        rx_frame_err,
    input  wire        rx_overrun,
    // Outgoing byte stream.
    input  wire        tx_ready,
    output reg         tx_valid,
    output reg  [7:0]  tx_data,
    // Reply bytes sent by the framing logic.
    input  wire        reply_valid,
    input  wire [4:0]  reply_index,
    input  wire [7:0]  reply_data,
    // Memory read port.
    output reg         mem_rd,
    output reg  [19:0] mem_addr,
    input  wire        mem_rvalid,
    input  wire [7:0]  mem_rdata,
    // Decoded record writes.
    output reg         hex_wr_valid,
    output reg  [19:0] hex_wr_addr,
    output reg  [7:0]  hex_wr_data,
    // Status.
    output reg  [15:0] sum_word,
    output reg         sum_valid,
    output reg         pw_ok,
    output reg         blank,
    output reg         halted
);
    localparam S_IDLE  = 4'h0;
    localparam S_PWADR = 4'h1;
    localparam S_BLANK = 4'h2;
    localparam S_PWCNT = 4'h3;
    localparam S_PWCMP = 4'h4;
    localparam S_HEX   = 4'h5;
    localparam S_SCAN  = 4'h6;
    localparam S_TXSUM = 4'h7;
    localparam S_ERRTX = 4'h8;
    localparam S_HALT  = 4'h9;
    localparam S_WAITE = 4'hA;

    reg [3:0]  state;
    reg [2:0]  mode;
    reg [2:0]  hp;
    reg [7:0]  rec_len;
    reg [7:0]  rec_type;
    reg [7:0]  rec_sum;
    reg [7:0]  rec_cnt;
    reg [15:0] rec_addr;
    reg [15:0] ext_addr;
    reg [15:0] ext_next;
    reg [19:0] ram_first;
    reg [19:0] ram_last;
    reg        ram_seen;
    reg [19:0] scan_end;
    reg        scan_two;
    reg        pend;
    reg [23:0] pw_len_loc;
    reg [23:0] pw_origin;
    reg [7:0]  pw_n;
    reg [7:0]  idx;
    reg [7:0]  pw_rx;
    reg [7:0]  prev1;
    reg [7:0]  prev2;
    reg [1:0]  err_cnt;
    reg        tx_hi_done;

    wire [19:0] hex_full = {ext_addr, 4'h0} + {4'h0, rec_addr};
    wire [7:0]  rec_sum_n = rec_sum + rx_data;
    wire        rx_err = rx_frame_err | rx_overrun;

    // Picks the stage that follows the password step for each mode.
    function [3:0] after_pw;
        input [2:0] m;
        begin
            case (m)
                `SBLC_MODE_WRITE: after_pw = S_HEX;
                `SBLC_MODE_RAM:   after_pw = S_HEX;
                `SBLC_MODE_SUM:   after_pw = S_SCAN;
                `SBLC_MODE_ERASE: after_pw = S_WAITE;
                default:          after_pw = S_IDLE;
            endcase
        end
    endfunction

    // Tells whether an address lies in the lower flash area.
    function in_low_flash;
        input [23:0] a;
        begin
            in_low_flash = (a >= {4'h0, `SBLC_FLASH_A_LO}) && (a <= {4'h0, `SBLC_FLASH_A_HI});
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= S_IDLE;
            mode         <= `SBLC_MODE_WRITE;
            hp           <= `SBLC_HP_MARK;
            rec_len      <= 8'h00;
            rec_type     <= 8'h00;
            rec_sum      <= 8'h00;
            rec_cnt      <= 8'h00;
            rec_addr     <= 16'h0000;
            ext_addr     <= 16'h0000;
            ext_next     <= 16'h0000;
            ram_first    <= 20'h0_0000;
            ram_last     <= 20'h0_0000;
            ram_seen     <= 1'b0;
            scan_end     <= 20'h0_0000;
            scan_two     <= 1'b0;
            pend         <= 1'b0;
            pw_len_loc   <= 24'h00_0000;
            pw_origin    <= 24'h00_0000;
            pw_n         <= 8'h00;
            idx          <= 8'h00;
            pw_rx        <= 8'h00;
            prev1        <= 8'h00;
            prev2        <= 8'h00;
            err_cnt      <= 2'h0;
            tx_hi_done   <= 1'b0;
            tx_valid     <= 1'b0;
            tx_data      <= 8'h00;
            mem_rd       <= 1'b0;
            mem_addr     <= 20'h0_0000;
            hex_wr_valid <= 1'b0;
            hex_wr_addr  <= 20'h0_0000;
            hex_wr_data  <= 8'h00;
            sum_word     <= 16'h0000;
            sum_valid    <= 1'b0;
            pw_ok        <= 1'b0;
            blank        <= 1'b0;
            halted       <= 1'b0;
        end else begin
            mem_rd       <= 1'b0;
            hex_wr_valid <= 1'b0;
            sum_valid    <= 1'b0;
            pw_ok        <= 1'b0;
            // Reply bytes 09H to 12H of the ID mode and 09H to 0CH of the status mode are summed as they go out.
            if (reply_valid && state == S_IDLE) begin
                if (mode == `SBLC_MODE_ID && reply_index >= `SBLC_ID_FIRST && reply_index <= `SBLC_ID_LAST) begin
                    sum_word  <= sum_word + {8'h00, reply_data};
                    sum_valid <= (reply_index == `SBLC_ID_LAST);
                end
                if (mode == `SBLC_MODE_STATUS && reply_index >= `SBLC_ST_FIRST && reply_index <= `SBLC_ST_LAST) begin
                    sum_word  <= sum_word + {8'h00, reply_data};
                    sum_valid <= (reply_index == `SBLC_ST_LAST);
                end
            end
            case (state)
                S_IDLE: begin
                    if (err_baud || err_cmd || (rx_valid && rx_err)) begin
                        tx_valid <= 1'b1;
                        err_cnt  <= 2'h0;
                        state    <= S_ERRTX;
                        if (err_baud)
                            tx_data <= `SBLC_ERR_BAUD;
                        else if (err_cmd)
                            tx_data <= `SBLC_ERR_CMD;
                        else if (rx_frame_err)
                            tx_data <= `SBLC_ERR_FRAME;
                        else
                            tx_data <= `SBLC_ERR_OVERRUN;
                    end else if (cmd_start) begin
                        mode     <= cmd_mode;
                        tx_hi_done <= 1'b0;
                        sum_word <= 16'h0000;
                        blank    <= 1'b0;
                        ram_seen <= 1'b0;
                        ext_addr <= 16'h0000;
                        hp       <= `SBLC_HP_MARK;
                        idx      <= 8'h00;
                        scan_two <= 1'b1;
                        mem_addr <= `SBLC_FLASH_A_LO;
                        scan_end <= `SBLC_FLASH_A_HI;
                        state    <= pw_needed ? S_PWADR : after_pw(cmd_mode);
                    end
                end
                S_ERRTX: begin
                    if (tx_ready) begin
                        if (err_cnt == `SBLC_ERR_REPEAT - 2'h1) begin
                            tx_valid <= 1'b0;
                            halted   <= 1'b1;
                            state    <= S_HALT;
                        end else begin
                            err_cnt <= err_cnt + 2'h1;
                        end
                    end
                end
                S_PWADR: begin
                    if (rx_valid) begin
                        if (rx_err) begin
                            halted <= 1'b1;
                            state  <= S_HALT;
                        end else begin
                            idx <= idx + 8'h01;
                            if (idx < 8'h03)
                                pw_len_loc <= {pw_len_loc[15:0], rx_data};
                            else
                                pw_origin <= {pw_origin[15:0], rx_data};
                            if (idx == {5'h00, `SBLC_PW_ADDR_LEN - 3'h1}) begin
                                if (!in_low_flash(pw_len_loc)) begin
                                    halted <= 1'b1;
                                    state  <= S_HALT;
                                end else begin
                                    blank    <= 1'b1;
                                    mem_addr <= `SBLC_BLANK_LO;
                                    state    <= S_BLANK;
                                end
                            end
                        end
                    end
                end
                S_BLANK: begin
                    if (!pend) begin
                        mem_rd <= 1'b1;
                        pend   <= 1'b1;
                    end else if (mem_rvalid) begin
                        pend <= 1'b0;
                        if (mem_rdata != `SBLC_BYTE_FF) begin
                            blank    <= 1'b0;
                            mem_addr <= pw_len_loc[19:0];
                            state    <= S_PWCNT;
                        end else if (mem_addr == `SBLC_FLASH_B_HI) begin
                            mem_addr <= `SBLC_FLASH_A_LO;
                            if (!in_low_flash(pw_origin)) begin
                                halted <= 1'b1;
                                state  <= S_HALT;
                            end else begin
                                pw_ok <= 1'b1;
                                state <= after_pw(mode);
                            end
                        end else begin
                            mem_addr <= mem_addr + 20'h0_0001;
                        end
                    end
                end
                S_PWCNT: begin
                    if (!pend) begin
                        mem_rd <= 1'b1;
                        pend   <= 1'b1;
                    end else if (mem_rvalid) begin
                        pend  <= 1'b0;
                        pw_n  <= mem_rdata;
                        idx   <= 8'h00;
                        if (mem_rdata < `SBLC_PW_MIN || pw_origin < {4'h0, `SBLC_FLASH_A_LO}
                            || pw_origin > {4'h0, `SBLC_PW_CEIL} - {16'h0000, mem_rdata}) begin
                            halted <= 1'b1;
                            state  <= S_HALT;
                        end else begin
                            mem_addr <= pw_origin[19:0];
                            state    <= S_PWCMP;
                        end
                    end
                end
                S_PWCMP: begin
                    if (!pend && rx_valid) begin
                        if (rx_err || (idx >= 8'h02 && rx_data == prev1 && prev1 == prev2)) begin
                            halted <= 1'b1;
                            state  <= S_HALT;
                        end else begin
                            pw_rx  <= rx_data;
                            prev2  <= prev1;
                            prev1  <= rx_data;
                            mem_rd <= 1'b1;
                            pend   <= 1'b1;
                        end
                    end else if (pend && mem_rvalid) begin
                        pend <= 1'b0;
                        if (mem_rdata != pw_rx) begin
                            halted <= 1'b1;
                            state  <= S_HALT;
                        end else if (idx == pw_n - 8'h01) begin
                            pw_ok    <= 1'b1;
                            mem_addr <= `SBLC_FLASH_A_LO;
                            state    <= after_pw(mode);
                        end else begin
                            idx      <= idx + 8'h01;
                            mem_addr <= mem_addr + 20'h0_0001;
                        end
                    end
                end
                S_HEX: begin
                    if (rx_valid && rx_err) begin
                        halted <= 1'b1;
                        state  <= S_HALT;
                    end else if (rx_valid) begin
                        rec_sum <= rec_sum_n;
                        case (hp)
                            `SBLC_HP_MARK: begin
                                rec_sum <= 8'h00;
                                if (rx_data == `SBLC_MARK)
                                    hp <= `SBLC_HP_LEN;
                            end
                            `SBLC_HP_LEN: begin
                                rec_len <= rx_data;
                                hp      <= `SBLC_HP_ADDR_H;
                            end
                            `SBLC_HP_ADDR_H: begin
                                rec_addr[15:8] <= rx_data;
                                hp             <= `SBLC_HP_ADDR_L;
                            end
                            `SBLC_HP_ADDR_L: begin
                                rec_addr[7:0] <= rx_data;
                                hp            <= `SBLC_HP_TYPE;
                            end
                            `SBLC_HP_TYPE: begin
                                rec_type <= rx_data;
                                rec_cnt  <= 8'h00;
                                if ((rx_data != `SBLC_REC_DATA && rx_data != `SBLC_REC_END
                                     && rx_data != `SBLC_REC_EXT)
                                    || (rx_data == `SBLC_REC_EXT && rec_len != `SBLC_EXT_LEN)
                                    || (rx_data == `SBLC_REC_END && rec_len != `SBLC_END_LEN)
                                    || (rx_data == `SBLC_REC_DATA && ext_addr >= `SBLC_EXT_LIMIT)) begin
                                    halted <= 1'b1;
                                    state  <= S_HALT;
                                end else begin
                                    hp <= (rec_len == 8'h00) ? `SBLC_HP_CSUM : `SBLC_HP_DATA;
                                end
                            end
                            `SBLC_HP_DATA: begin
                                rec_cnt <= rec_cnt + 8'h01;
                                if (rec_type == `SBLC_REC_EXT) begin
                                    ext_next <= {ext_next[7:0], rx_data};
                                end else begin
                                    // Writes leave before the record checksum is known; a bad record halts anyway.
                                    hex_wr_valid <= 1'b1;
                                    hex_wr_addr  <= hex_full;
                                    hex_wr_data  <= rx_data;
                                    rec_addr     <= rec_addr + 16'h0001;
                                    if (!ram_seen)
                                        ram_first <= hex_full;
                                    ram_seen <= 1'b1;
                                    ram_last <= hex_full;
                                end
                                if (rec_cnt == rec_len - 8'h01)
                                    hp <= `SBLC_HP_CSUM;
                            end
                            default: begin
                                hp <= `SBLC_HP_MARK;
                                if (rec_sum_n != 8'h00) begin
                                    halted <= 1'b1;
                                    state  <= S_HALT;
                                end else if (rec_type == `SBLC_REC_EXT) begin
                                    ext_addr <= ext_next;
                                end else if (rec_type == `SBLC_REC_END) begin
                                    if (mode == `SBLC_MODE_RAM) begin
                                        scan_two <= 1'b0;
                                        mem_addr <= ram_first;
                                        scan_end <= ram_last;
                                    end
                                    state <= (mode == `SBLC_MODE_RAM && !ram_seen) ? S_TXSUM : S_SCAN;
                                end
                            end
                        endcase
                    end
                end
                S_WAITE: begin
                    if (erase_done) begin
                        if (!erase_chip) begin
                            scan_two <= 1'b0;
                            mem_addr <= erase_lo;
                            scan_end <= erase_hi;
                        end
                        state <= S_SCAN;
                    end
                end
                S_SCAN: begin
                    if (!pend) begin
                        mem_rd <= 1'b1;
                        pend   <= 1'b1;
                    end else if (mem_rvalid) begin
                        pend     <= 1'b0;
                        sum_word <= sum_word + {8'h00, mem_rdata};
                        if (mem_addr != scan_end) begin
                            mem_addr <= mem_addr + 20'h0_0001;
                        end else if (scan_two) begin
                            scan_two <= 1'b0;
                            mem_addr <= `SBLC_FLASH_B_LO;
                            scan_end <= `SBLC_FLASH_B_HI;
                        end else begin
                            tx_hi_done <= 1'b0;
                            state      <= S_TXSUM;
                        end
                    end
                end
                S_TXSUM: begin
                    tx_valid <= 1'b1;
                    tx_data  <= tx_hi_done ? sum_word[7:0] : sum_word[15:8];
                    if (tx_valid && tx_ready) begin
                        if (tx_hi_done) begin
                            tx_valid  <= 1'b0;
                            sum_valid <= 1'b1;
                            state     <= S_IDLE;
                        end else begin
                            tx_hi_done <= 1'b1;
                            tx_data    <= sum_word[7:0];
                        end
                    end
                end
                S_HALT: begin
                    halted <= 1'b1;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // sblc_checker

// >>> test/sblc_far.sv
// Memory and transmit sink model at the far side of the checking block.
`timescale 1ns/1ps
module sblc_far (input wire core_clk, rst_n, mem_rd, blank_top, input wire [19:0] mem_addr,
    output reg mem_rvalid, output reg [7:0] mem_rdata, output reg tx_ready);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {mem_rvalid, mem_rdata, tx_ready} <= 10'h000;
        end else begin
            // Stalling every other cycle proves that replies are held, not dropped.
            tx_ready <= ~tx_ready;
            mem_rvalid <= mem_rd;
            // Idle data keeps changing so a late capture cannot pass by luck.
            if (!mem_rd)
                mem_rdata <= ~mem_rdata;
            else if (blank_top && mem_addr >= 20'hF_FFE0)
                mem_rdata <= 8'hFF;
            else
                mem_rdata <= mem_addr[7:0] ^ 8'hA5;
        end
    end
endmodule // sblc_far

// >>> test/sblc_checker_asserts.sv
// Concurrent checks on the ports of the checking block.
`timescale 1ns/1ps
module sblc_checker_asserts (input wire core_clk, rst_n, err_baud, err_cmd, tx_ready, tx_valid, rx_valid,
    hex_wr_valid, mem_rd, sum_valid, pw_ok, halted, input wire [7:0] tx_data, rx_data, hex_wr_data);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_hold; tx_valid && !tx_ready |=> tx_valid && tx_data == $past(tx_data); endproperty
    a_hold: assert property (p_hold) else $error("stalled tx byte changed");
    property p_baud; err_baud && !halted && !tx_valid |=> tx_valid && tx_data == 8'h62; endproperty
    a_baud: assert property (p_baud) else $error("baud error code wrong");
    property p_cmd; err_cmd && !err_baud && !halted && !tx_valid |=> tx_valid && tx_data == 8'h63; endproperty
    a_cmd: assert property (p_cmd) else $error("command error code wrong");
    property p_sticky; halted |=> halted; endproperty
    a_sticky: assert property (p_sticky) else $error("halt left without reset");
    property p_quiet; halted |-> !tx_valid && !hex_wr_valid && !mem_rd && !sum_valid && !pw_ok; endproperty
    a_quiet: assert property (p_quiet) else $error("activity while halted");
    property p_wr; hex_wr_valid |-> $past(rx_valid) && hex_wr_data == $past(rx_data); endproperty
    a_wr: assert property (p_wr) else $error("decoded byte not from stream");
    property p_pw; pw_ok |=> !pw_ok; endproperty
    a_pw: assert property (p_pw) else $error("password pass not a pulse");
    property p_sum; sum_valid |=> !sum_valid; endproperty
    a_sum: assert property (p_sum) else $error("sum final not a pulse");
    c_halt: cover property (halted && !tx_valid);
    c_pw: cover property (pw_ok);
    c_sum: cover property (sum_valid);
    c_wr: cover property (hex_wr_valid);
endmodule // sblc_checker_asserts
bind sblc_checker sblc_checker_asserts u_chk (.*);

// >>> test/tb_top.sv
// Self-checking bench of the boot loader checking block.
`timescale 1ns/1ps
module tb_top;
    reg core_clk = 1'b0, rst_n = 1'b0, cmd_start = 1'b0, pw_needed = 1'b0, err_baud = 1'b0, err_cmd = 1'b0;
    reg rx_valid = 1'b0, rx_frame_err = 1'b0, rx_overrun = 1'b0, reply_valid = 1'b0, blank_top = 1'b0;
    reg erase_chip = 1'b0, erase_done = 1'b0, pw_seen = 1'b0;
    reg [19:0] erase_lo = 20'h0_0000, erase_hi = 20'h0_0000, wr_a;
    reg [2:0] cmd_mode = 3'h0;
    reg [4:0] reply_index = 5'h00;
    reg [7:0] rx_data = 8'h00, reply_data = 8'h00, wr_d, txq[$];
    reg [15:0] sum_c;
    wire tx_valid, tx_ready, mem_rd, mem_rvalid, hex_wr_valid, sum_valid, pw_ok, blank, halted;
    wire [7:0] tx_data, mem_rdata, hex_wr_data;
    wire [19:0] mem_addr, hex_wr_addr;
    wire [15:0] sum_word;
    integer mismatches = 0, comparisons = 0, i;
    sblc_checker dut (.*);
    sblc_far far (.*);
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) txq.push_back(tx_data);
        if (hex_wr_valid) {wr_a, wr_d} <= {hex_wr_addr, hex_wr_data};
        if (sum_valid) sum_c <= sum_word;
        if (pw_ok) pw_seen <= 1'b1;
    end
    task cmp(input [19:0] got, input [19:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task go(input [2:0] m, input p);
        begin
            rst_n = 1'b0;
            repeat (3) @(negedge core_clk);
            rst_n = 1'b1;
            txq.delete();
            pw_seen = 1'b0;
            {cmd_mode, pw_needed, cmd_start} = {m, p, 1'b1};
            @(negedge core_clk) cmd_start = 1'b0;
        end
    endtask
    // Bytes are paced six cycles apart so every pending memory read lands first.
    task rec(input [55:0] r, input integer n);
        for (i = 0; i < n; i = i + 1) begin
            {rx_valid, rx_data} = {1'b1, r[55 - 8 * i -: 8]};
            @(negedge core_clk) rx_valid = 1'b0;
            repeat (5) @(negedge core_clk);
        end
    endtask
    task t_err(input [1:0] k, input [7:0] code);
        begin
            // Status mode stays idle, where error events are honoured.
            go(3'h4, 1'b0);
            {err_baud, err_cmd, rx_frame_err, rx_overrun} = 4'b1000 >> k;
            if (k[1]) rec(56'h0, 1);
            @(negedge core_clk) {err_baud, err_cmd, rx_frame_err, rx_overrun} = 4'b0000;
            repeat (20) @(negedge core_clk);
            cmp(txq.size(), 3);
            foreach (txq[i]) cmp(txq[i], code);
            cmp(halted, 1'b1);
            $display("error reply test done");
        end
    endtask
    task t_status(input [2:0] m, input [15:0] exp);
        begin
            go(m, 1'b0);
            for (i = 1; i <= 19; i = i + 1) begin
                {reply_valid, reply_index, reply_data} = {1'b1, i[4:0], 8'h03 * i[7:0]};
                @(negedge core_clk);
            end
            reply_valid = 1'b0;
            repeat (3) @(negedge core_clk);
            cmp(sum_c, exp);
            $display("reply sum test done");
        end
    endtask
    task t_pw(input [55:0] r, input bt, input hlt, input [7:0] last);
        begin
            blank_top = bt;
            go(3'h6, 1'b1);
            rec(r, 6);
            // Model bytes are address xor A5H, so 040ADH holds 08H and 04000H starts A5H A4H A7H.
            if (last != 8'h00) begin
                repeat (6) @(negedge core_clk);
                rec(56'hA5A4_A7A6_A1A0_A3, 7);
                rec({last, 48'h0000_0000_0000}, 1);
            end
            repeat (120) @(negedge core_clk);
            cmp(halted, hlt);
            cmp(blank, bt);
            cmp(pw_seen, !hlt);
            cmp(txq.size(), 0);
            $display("password test done");
        end
    endtask
    task t_ram;
        begin
            go(3'h1, 1'b0);
            rec(56'h3A01_0010_005A_95, 7);
            cmp({wr_a, wr_d}, {20'h0_0010, 8'h5A});
            rec(56'h3A00_0000_01FF_00, 6);
            repeat (30) @(negedge core_clk);
            cmp({txq[0], txq[1]}, 16'h00B5);
            cmp(sum_c, 16'h00B5);
            {cmd_mode, cmd_start} = {3'h1, 1'b1};
            @(negedge core_clk) cmd_start = 1'b0;
            rec(56'h4A3A_0000_0005_FB, 7);
            cmp(halted, 1'b1);
            cmp(txq.size(), 2);
            $display("record test done");
        end
    endtask
    task t_erase;
        begin
            {erase_chip, erase_lo, erase_hi} = {1'b0, 20'h0_4000, 20'h0_4001};
            go(3'h5, 1'b0);
            erase_done = 1'b1;
            @(negedge core_clk) erase_done = 1'b0;
            repeat (20) @(negedge core_clk);
            cmp({txq[0], txq[1]}, 16'h0149);
            cmp(sum_c, 16'h0149);
            $display("erase sum test done");
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        #400000;
        mismatches = mismatches + 1;
        tally_and_finish;
    end
    initial begin
        t_err(2'h0, 8'h62);
        t_err(2'h1, 8'h63);
        t_err(2'h2, 8'hA1);
        t_err(2'h3, 8'hA3);
        t_status(3'h4, 16'h007E);
        t_status(3'h3, 16'h0195);
        t_pw(56'h0040_0000_4010_00, 1'b1, 1'b0, 8'h00);
        t_pw(56'h0030_0000_4010_00, 1'b0, 1'b1, 8'h00);
        t_pw(56'h0040_AD00_7EF9_00, 1'b0, 1'b1, 8'h00);
        t_pw(56'h0040_AD00_4000_00, 1'b0, 1'b0, 8'hA2);
        t_pw(56'h0040_AD00_4000_00, 1'b0, 1'b1, 8'hA3);
        t_ram;
        t_erase;
        tally_and_finish;
    end
endmodule // tb_top
